// >>> core/cpk_capture.sv
`timescale 1ns/1ps
module cpk_capture
(
    input  wire logic                       clk,
    input  wire logic                       reset,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [cpk_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       pixelClockIn,
    input  wire logic                       hsyncIn,
    input  wire logic                       vsyncIn,
    input  wire logic [7:0]                 camData,
    input  wire logic                       dmaAck,
    input  wire logic                       stopMode,
    output logic                            dmaReq,
    output logic [31:0]                     dmaData,
    output logic                            globalCameraIrq
);
    import cpk_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_FRAME} cpk_state_t;

    cpk_ctrl_t        ctrl_ff;
    cpk_ctrl_t        nxt_ctrl;
    cpk_win_t         cwStart_ff;
    cpk_win_t         cwSize_ff;
    cpk_state_t       st_ff;
    cpk_state_t       nxt_st;
    cpk_pin_t         pin;
    logic [PIN_W-1:0] pinSync;
    logic [IRQ_N-1:0] ier_ff;
    logic [IRQ_N-1:0] raw_ff;
    logic [IRQ_N-1:0] evt;
    logic [IRQ_N-1:0] clrPulse;
    logic [IRQ_N-1:0] mis;
    logic [31:0]      word;
    logic [31:0]      rdMux;
    logic [CNT_W-1:0] pixCnt_ff;
    logic [CNT_W-1:0] lineCnt_ff;
    logic             pclkPrev_ff, hActPrev_ff, vActPrev_ff, wordValid_ff, wordStb;
    logic             pixEdge, hAct, vAct, hRise, vRise, vFall, dataValid;
    logic             inFrame, startEdge, framing, lineEnd, frameEnd, keepByte, keepLine;
    logic             inWin, byteStb, consumed, overrun, hwClrCap, run, oddEff;
    logic             apbAccess, apbWr, apbSetup, addrHit;
    logic [1:0]       bsmEff;

    // ------------------------------------------------------------
    // Camera pins: synchronised, then edge detected on the local clock.
    // ------------------------------------------------------------
    cpk_sync2 #(.W(PIN_W)) u_sync (
        .clk   (clk),
        .reset (reset),
        .d     ({pixelClockIn, hsyncIn, vsyncIn, camData}),
        .q     (pinSync)
    );

    assign pin       = cpk_pin_t'(pinSync);
    assign run       = !stopMode;
    assign pixEdge   = run && (ctrl_ff.pckPol ? (pin.pclk && !pclkPrev_ff)
                                              : (!pin.pclk && pclkPrev_ff));
    assign hAct      = pin.hsync == ctrl_ff.hsPol;
    assign vAct      = pin.vsync == ctrl_ff.vsPol;
    assign hRise     = pixEdge && hAct && !hActPrev_ff;
    assign vRise     = pixEdge && vAct && !vActPrev_ff;
    assign vFall     = pixEdge && !vAct && vActPrev_ff;
    // In compressed mode the horizontal sync only qualifies data.
    assign dataValid = !hAct && !vAct;
    assign inFrame   = st_ff == ST_FRAME;
    assign startEdge = st_ff == ST_WAIT && ctrl_ff.capture && vFall;
    assign framing   = inFrame || startEdge;
    assign lineEnd   = inFrame && hRise && !ctrl_ff.jpeg;
    assign frameEnd  = inFrame && vRise;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pclkPrev_ff <= 1'b0;
            hActPrev_ff <= 1'b0;
            // Blanking is assumed after reset, so an idle camera gives no false edge.
            vActPrev_ff <= 1'b1;
        end
        else if (run)
        begin
            pclkPrev_ff <= pin.pclk;
            hActPrev_ff <= pixEdge ? hAct : hActPrev_ff;
            vActPrev_ff <= pixEdge ? vAct : vActPrev_ff;
        end
    end

    // ------------------------------------------------------------
    // Position counters; 14 bits cover 8192 pixels of two bytes.
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset || !framing)
        begin
            pixCnt_ff  <= '0;
            lineCnt_ff <= '0;
        end
        else if (lineEnd)
        begin
            pixCnt_ff  <= '0;
            lineCnt_ff <= lineCnt_ff + 14'h0001;
        end
        else if (framing && pixEdge && dataValid && !ctrl_ff.jpeg)
        begin
            pixCnt_ff  <= pixCnt_ff + 14'h0001;
        end
    end

    // ------------------------------------------------------------
    // Window and decimation selection.
    // ------------------------------------------------------------
    assign inWin = !ctrl_ff.crop || ctrl_ff.jpeg ||
                   ((pixCnt_ff >= cwStart_ff.horiz) &&
                    ({1'b0, pixCnt_ff} < ({1'b0, cwStart_ff.horiz} + {1'b0, cwSize_ff.horiz})) &&
                    (lineCnt_ff >= cwStart_ff.vert) &&
                    ({1'b0, lineCnt_ff} < ({1'b0, cwStart_ff.vert} + {1'b0, cwSize_ff.vert})));

    // Y-only keeps the odd bytes of the interleaved chroma/luma stream.
    assign bsmEff   = (ctrl_ff.fmt == FMT_YONLY) ? BSM_HALF : ctrl_ff.byteSel;
    assign oddEff   = (ctrl_ff.fmt == FMT_YONLY) ? 1'b1 : ctrl_ff.oddByte;
    assign keepByte = ctrl_ff.jpeg ||
                      (bsmEff == BSM_ALL) ||
                      (bsmEff == BSM_HALF  && pixCnt_ff[0] == oddEff) ||
                      (bsmEff == BSM_QUART && pixCnt_ff[1:0] == 2'h0) ||
                      (bsmEff == BSM_TWO4  && !pixCnt_ff[1]);
    assign keepLine = ctrl_ff.jpeg || !ctrl_ff.lineSel ||
                      (lineCnt_ff[0] == ctrl_ff.oddLine);

    // Bytes enter in arrival order, so four mono pixels or two RGB565
    // pixels fill a word with the later pixel in the upper lanes.
    assign byteStb = framing && pixEdge && dataValid && keepByte && keepLine && inWin;

    cpk_packer u_pack (
        .clk      (clk),
        .reset    (reset),
        .byteStb  (byteStb),
        .byteData (pin.data),
        .flush    (frameEnd),
        .wordStb  (wordStb),
        .wordData (word)
    );

    // ------------------------------------------------------------
    // Output word and DMA request.
    // ------------------------------------------------------------
    assign consumed = dmaAck || (apbAccess && !pwrite && paddr == OFF_DR);
    assign overrun  = wordStb && wordValid_ff && !consumed;
    assign dmaReq   = wordValid_ff;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wordValid_ff <= 1'b0;
            dmaData      <= '0;
        end
        else
        begin
            wordValid_ff <= wordStb || (wordValid_ff && !consumed);
            dmaData      <= wordStb ? word : dmaData;
        end
    end

    // ------------------------------------------------------------
    // Capture sequencing.
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st   = st_ff;
        hwClrCap = 1'b0;
        case (st_ff)
            ST_IDLE:
            begin
                if (ctrl_ff.capture)
                    nxt_st = ST_WAIT;
            end
            ST_WAIT:
            begin
                if (!ctrl_ff.capture)
                    nxt_st = ST_IDLE;
                else if (vFall)
                    nxt_st = ST_FRAME;
            end
            ST_FRAME:
            begin
                if (overrun && ctrl_ff.snapshot)
                begin
                    nxt_st   = ST_IDLE;
                    hwClrCap = 1'b1;
                end
                else if (frameEnd)
                begin
                    hwClrCap = ctrl_ff.snapshot;
                    nxt_st   = (ctrl_ff.capture && !ctrl_ff.snapshot) ? ST_WAIT : ST_IDLE;
                end
            end
            default:
            begin
                nxt_st = ST_IDLE;
            end
        endcase
        if (!run)
        begin
            nxt_st   = st_ff;
            hwClrCap = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            st_ff <= ST_IDLE;
        else
            st_ff <= nxt_st;
    end

    // ------------------------------------------------------------
    // Interrupt sources and status.
    // ------------------------------------------------------------
    always_comb
    begin
        evt            = '0;
        evt[IRQ_LINE]  = lineEnd;
        evt[IRQ_FRAME] = frameEnd;
        evt[IRQ_OVR]   = overrun;
        evt[IRQ_FSYNC] = vRise && !ctrl_ff.embSync;
        evt[IRQ_ERR]   = 1'b0;
    end

    assign clrPulse        = (apbWr && paddr == OFF_ICR) ? pwdata[IRQ_N-1:0] : '0;
    assign mis             = raw_ff & ier_ff;
    assign globalCameraIrq = |mis;

    always_ff @(posedge clk)
    begin
        if (reset)
            raw_ff <= IRQ_RST;
        else
            raw_ff <= (raw_ff & ~clrPulse) | evt;
    end

    // ------------------------------------------------------------
    // Register bus slave: no wait states, error on unmapped address.
    // ------------------------------------------------------------
    assign apbSetup  = psel && !penable;
    assign apbAccess = psel && penable;
    assign apbWr     = apbAccess && pwrite;
    assign pready    = 1'b1;
    assign addrHit   = paddr == OFF_CTRL || paddr == OFF_RIS || paddr == OFF_IER ||
                       paddr == OFF_MIS || paddr == OFF_ICR || paddr == OFF_CWSTRT ||
                       paddr == OFF_CWSIZE || paddr == OFF_DR;
    assign pslverr   = apbAccess && !addrHit;

    assign rdMux = (paddr == OFF_CTRL)   ? 32'(ctrl_ff) :
                   (paddr == OFF_RIS)    ? {27'h0, raw_ff} :
                   (paddr == OFF_IER)    ? {27'h0, ier_ff} :
                   (paddr == OFF_MIS)    ? {27'h0, mis} :
                   (paddr == OFF_CWSTRT) ? 32'(cwStart_ff) :
                   (paddr == OFF_CWSIZE) ? 32'(cwSize_ff) :
                   (paddr == OFF_DR)     ? dmaData : REG_RST;

    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        if (apbWr && paddr == OFF_CTRL)
            nxt_ctrl = cpk_ctrl_t'(pwdata);
        nxt_ctrl.rsv = '0;
        if (hwClrCap)
            nxt_ctrl.capture = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ctrl_ff    <= cpk_ctrl_t'(REG_RST);
            ier_ff     <= IRQ_RST;
            cwStart_ff <= cpk_win_t'(REG_RST);
            cwSize_ff  <= cpk_win_t'(REG_RST);
            prdata     <= REG_RST;
        end
        else
        begin
            ctrl_ff    <= nxt_ctrl;
            ier_ff     <= (apbWr && paddr == OFF_IER) ? pwdata[IRQ_N-1:0] : ier_ff;
            cwStart_ff <= (apbWr && paddr == OFF_CWSTRT) ? cpk_win_t'(pwdata & 32'h3FFF_3FFF)
                                                        : cwStart_ff;
            cwSize_ff  <= (apbWr && paddr == OFF_CWSIZE) ? cpk_win_t'(pwdata & 32'h3FFF_3FFF)
                                                        : cwSize_ff;
            prdata     <= apbSetup ? rdMux : prdata;
        end
    end

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    a_word_dma_req: assert property (@(posedge clk) disable iff (reset)
        wordStb |=> dmaReq && dmaData == $past(word))
        else $error("completed word raised no request");
    a_overrun_flag: assert property (@(posedge clk) disable iff (reset)
        wordStb && dmaReq && !consumed |=> raw_ff[IRQ_OVR])
        else $error("overrun not flagged");
    a_raw_sticky: assert property (@(posedge clk) disable iff (reset)
        raw_ff[IRQ_FRAME] && !clrPulse[IRQ_FRAME] |=> raw_ff[IRQ_FRAME])
        else $error("raw status lost without clear");
    a_mis_readback: assert property (@(posedge clk) disable iff (reset)
        apbSetup && paddr == OFF_MIS |=> prdata[IRQ_N-1:0] == ($past(raw_ff) & $past(ier_ff)))
        else $error("masked status read wrong");
    a_snap_clear: assert property (@(posedge clk) disable iff (reset)
        frameEnd && ctrl_ff.snapshot && run |=> !ctrl_ff.capture && st_ff == ST_IDLE)
        else $error("snapshot did not stop");
    a_line_irq_out: assert property (@(posedge clk) disable iff (reset)
        lineEnd && ier_ff[IRQ_LINE] |=> globalCameraIrq)
        else $error("enabled source missed global interrupt");
    a_fsync_nocap: assert property (@(posedge clk) disable iff (reset)
        vRise && !ctrl_ff.embSync && !clrPulse[IRQ_FSYNC] |=> raw_ff[IRQ_FSYNC])
        else $error("frame sync not flagged");
    a_err_embedded: assert property (@(posedge clk) disable iff (reset)
        $rose(raw_ff[IRQ_ERR]) |-> $past(ctrl_ff.embSync))
        else $error("order error outside embedded mode");
    a_cont_finish: assert property (@(posedge clk) disable iff (reset)
        inFrame && !frameEnd && !overrun |=> st_ff == ST_FRAME)
        else $error("frame abandoned early");
    a_stop_freeze: assert property (@(posedge clk) disable iff (reset)
        stopMode ##1 stopMode |-> $stable(pixCnt_ff) && $stable(st_ff))
        else $error("block moved while stopped");
endmodule : cpk_capture

// >>> core/cpk_pkg.sv
package cpk_pkg;

    // ------------------------------------------------------------
    // Register map, byte addresses on the register bus.
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W     = 8;
    localparam logic [7:0]  OFF_CTRL   = 8'h00;
    localparam logic [7:0]  OFF_RIS    = 8'h08;
    localparam logic [7:0]  OFF_IER    = 8'h0C;
    localparam logic [7:0]  OFF_MIS    = 8'h10;
    localparam logic [7:0]  OFF_ICR    = 8'h14;
    localparam logic [7:0]  OFF_CWSTRT = 8'h20;
    localparam logic [7:0]  OFF_CWSIZE = 8'h24;
    localparam logic [7:0]  OFF_DR     = 8'h28;

    // ------------------------------------------------------------
    // Interrupt sources, reset values and counter widths.
    // ------------------------------------------------------------
    localparam int unsigned IRQ_N      = 5;
    localparam int unsigned IRQ_LINE   = 0;
    localparam int unsigned IRQ_FRAME  = 1;
    localparam int unsigned IRQ_OVR    = 2;
    localparam int unsigned IRQ_FSYNC  = 3;
    localparam int unsigned IRQ_ERR    = 4;
    localparam logic [4:0]  IRQ_RST    = 5'h00;
    localparam logic [31:0] REG_RST    = 32'h0000_0000;
    localparam int unsigned CNT_W      = 14;
    localparam int unsigned PIN_W      = 11;

    localparam logic [1:0]  FMT_MONO   = 2'h0;
    localparam logic [1:0]  FMT_RGB    = 2'h1;
    localparam logic [1:0]  FMT_YCC    = 2'h2;
    localparam logic [1:0]  FMT_YONLY  = 2'h3;
    localparam logic [1:0]  BSM_ALL    = 2'h0;
    localparam logic [1:0]  BSM_HALF   = 2'h1;
    localparam logic [1:0]  BSM_QUART  = 2'h2;
    localparam logic [1:0]  BSM_TWO4   = 2'h3;

    // ------------------------------------------------------------
    // Carriers.
    // ------------------------------------------------------------
    typedef struct packed {
        logic [16:0] rsv;
        logic [1:0]  fmt;
        logic        oddLine;
        logic        lineSel;
        logic        oddByte;
        logic [1:0]  byteSel;
        logic        vsPol;
        logic        hsPol;
        logic        pckPol;
        logic        embSync;
        logic        jpeg;
        logic        crop;
        logic        snapshot;
        logic        capture;
    } cpk_ctrl_t;

    typedef struct packed {
        logic [1:0]       rsvHi;
        logic [CNT_W-1:0] vert;
        logic [1:0]       rsvLo;
        logic [CNT_W-1:0] horiz;
    } cpk_win_t;

    typedef struct packed {
        logic       pclk;
        logic       hsync;
        logic       vsync;
        logic [7:0] data;
    } cpk_pin_t;

endpackage : cpk_pkg

// >>> core/cpk_sync2.sv
`timescale 1ns/1ps
module cpk_sync2 #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            meta_ff <= '0;
            q       <= '0;
        end
        else
        begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule : cpk_sync2

// >>> core/cpk_packer.sv
`timescale 1ns/1ps
module cpk_packer (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        byteStb,
    input  wire logic [7:0]  byteData,
    input  wire logic        flush,
    output logic             wordStb,
    output logic      [31:0] wordData
);
    logic [31:0] acc_ff;
    logic [31:0] nxt_acc;
    logic [1:0]  cnt_ff;
    logic [1:0]  nxt_cnt;
    logic        nxt_stb;
    logic [31:0] nxt_word;

    // Earliest byte lands in the lowest lane; an emitted word clears the
    // accumulator so a flushed partial word carries zeros above its bytes.
    always_comb
    begin
        nxt_acc  = acc_ff;
        nxt_cnt  = cnt_ff;
        nxt_stb  = 1'b0;
        nxt_word = wordData;
        if (byteStb)
        begin
            nxt_acc[{cnt_ff, 3'h0} +: 8] = byteData;
            nxt_cnt = cnt_ff + 2'h1;
        end
        if ((byteStb && cnt_ff == 2'h3) || (flush && (byteStb || cnt_ff != 2'h0)))
        begin
            nxt_word = nxt_acc;
            nxt_stb  = 1'b1;
            nxt_acc  = '0;
            nxt_cnt  = 2'h0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            acc_ff   <= '0;
            cnt_ff   <= 2'h0;
            wordStb  <= 1'b0;
            wordData <= '0;
        end
        else
        begin
            acc_ff   <= nxt_acc;
            cnt_ff   <= nxt_cnt;
            wordStb  <= nxt_stb;
            wordData <= nxt_word;
        end
    end

    a_pad_partial: assert property (@(posedge clk) disable iff (reset)
        flush && !byteStb && cnt_ff == 2'h1 |=> wordStb && wordData[31:8] == 24'h0)
        else $error("partial word not zero padded");
    a_first_low_lane: assert property (@(posedge clk) disable iff (reset)
        byteStb && !flush && cnt_ff == 2'h0 |=> acc_ff[7:0] == $past(byteData))
        else $error("first byte not in lowest lane");
endmodule : cpk_packer

// >>> test/cpk_cam_model.sv
`timescale 1ns/1ps
module cpk_cam_model (
    output logic       pclk,
    output logic       hsync,
    output logic       vsync,
    output logic [7:0] data
);
    initial
    begin
        pclk = 1'b0;
        hsync = 1'b0;
        vsync = 1'b1;
        data = 8'h00;
    end

    // Pixel clock runs only around a frame; blanked data is scrambled.
    task automatic frame(input logic [7:0] b[$]);
        int i;
        #20;
        for (i = -1; i < b.size() + 2; i++)
        begin
            #400 pclk = 1'b0;
            vsync = !(i >= 0 && i < b.size());
            data = vsync ? ~data : b[i];
            #400 pclk = 1'b1;
        end
        #400 pclk = 1'b0;
    endtask : frame
endmodule : cpk_cam_model

// >>> test/tb_camera_parallel_capture_packer.sv
`timescale 1ns/1ps
module tb_camera_parallel_capture_packer;
    import cpk_pkg::*;
    localparam logic [32:0] ALL = 33'h1_FFFF_FFFF;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, camData;
    logic [31:0] pwdata, prdata, dmaData;
    logic        pclk, hsyncIn, vsyncIn, dmaAck, dmaReq, irq, ackEn, stop;
    logic [32:0] expQ[$], mskQ[$], rdMask, ierVal;
    logic [31:0] dmaQ[$], lastW[$];
    int          bad_count, checks_done, cycles;

    cpk_capture i_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pixelClockIn(pclk), .hsyncIn(hsyncIn), .vsyncIn(vsyncIn),
        .camData(camData), .dmaAck(dmaAck), .stopMode(stop), .dmaReq(dmaReq),
        .dmaData(dmaData), .globalCameraIrq(irq));
    cpk_cam_model i_cam (.pclk(pclk), .hsync(hsyncIn), .vsync(vsyncIn), .data(camData));

    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic give_verdict;
        if (bad_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    task automatic apb(input logic w, input logic [7:0] a, input logic [32:0] e,
                       input logic [32:0] m);
        if (!w)
        begin
            expQ.push_back(e);
            mskQ.push_back(m);
        end
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= e[31:0];
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // Sends a frame and notes the packed words that it should yield.
    task automatic shot(input int n, input bit yOnly);
        logic [7:0] b[$];
        logic [7:0] k[$];
        int         i;
        lastW = {};
        for (i = 0; i < n; i++)
        begin
            b.push_back($urandom);
            if (!yOnly || i[0])
                k.push_back(b[i]);
        end
        while (k.size() % 4)
            k.push_back(8'h00);
        for (i = 0; i < k.size(); i += 4)
            lastW.push_back({k[i+3], k[i+2], k[i+1], k[i]});
        if (ackEn)
            dmaQ = {dmaQ, lastW};
        i_cam.frame(b);
        for (i = 0; i < 60 && dmaQ.size() > 0; i++)
            @(posedge clk);
        repeat (8) @(posedge clk);
    endtask : shot

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            give_verdict;
        end
        if (psel && penable && !pwrite)
        begin
            rdMask = mskQ.pop_front();
            check({pslverr, prdata} & rdMask, expQ.pop_front() & rdMask);
        end
        if (dmaAck)
            dmaAck <= 1'b0;
        else if (dmaReq === 1'b1 && ackEn)
        begin
            check({1'b0, dmaData}, {1'b0, dmaQ.pop_front()});
            dmaAck <= 1'b1;
        end
    end

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        {reset, psel, penable, pwrite, stop, paddr, pwdata, dmaAck, ackEn} = {5'h10, 8'h00, 34'h1};
        bad_count = 0;
        checks_done = 0;
        cycles = 0;
        ierVal = $urandom(58);
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        apb(0, OFF_IER, 0, ALL);
        ierVal = $urandom & 32'h1F;
        apb(1, OFF_IER, ierVal, 0);
        apb(0, OFF_IER, ierVal, ALL);
        apb(1, OFF_RIS, 33'h1F, 0);
        apb(0, OFF_RIS, 0, ALL);
        apb(0, 8'h3C, 33'h1_0000_0000, ALL);
        apb(1, OFF_IER, 33'h02, 0);
        apb(1, OFF_CTRL, 33'hE1, 0);
        shot(6, 0);
        apb(0, OFF_RIS, 33'h0A, 33'h0A);
        apb(0, OFF_MIS, 33'h02, ALL);
        check(irq, 1'b1);
        apb(1, OFF_ICR, 33'h1F, 0);
        apb(0, OFF_RIS, 0, 33'h1F);
        check(irq, 1'b0);
        apb(1, OFF_CTRL, 33'h60E3, 0);
        shot(8, 1);
        apb(0, OFF_CTRL, 33'h60E2, ALL);
        apb(1, OFF_CTRL, 33'hE9, 0);
        shot(5, 0);
        ackEn <= 1'b0;
        apb(1, OFF_CTRL, 33'hE1, 0);
        shot(8, 0);
        apb(0, OFF_RIS, 33'h04, 33'h04);
        apb(0, OFF_DR, {1'b0, lastW[1]}, ALL);
        apb(1, OFF_CTRL, 33'hE0, 0);
        apb(1, OFF_ICR, 33'h1F, 0);
        shot(4, 0);
        apb(0, OFF_RIS, 33'h08, 33'h0A);
        apb(1, OFF_ICR, 33'h1F, 0);
        stop <= 1'b1;
        shot(4, 0);
        apb(0, OFF_RIS, 0, 33'h1F);
        stop <= 1'b0;
        give_verdict;
    end
endmodule : tb_camera_parallel_capture_packer
